// *** rtl/tsd_pkg.sv ***
// package: constants, types and glyph table for the terminal status display encoder
//
// Overview of operation
// - two presentations: one segment per terminal, or packed 16-bit word in hex
// - segment mode digit one a..dp: forward, reverse, general inputs one to six
// - segment mode digit two: a general seven, d safety enable, f/g/dp comm commands
// - segment mode digit three a..e: transistor outputs one to four, relay output a
// - segment mode digit four a: alarm relay make contact closed
// - segment mode, local or comm, all terminals off: only segment g lit on all four digits
// - hex mode word bits 15..0; unassigned bits read zero
// - hex digits: four = bits 15..12, three 11..8, two 7..4, one 3..0
// - input word: forward bit 0, reverse bit 1, one while shorted
// - general inputs one..seven at bits 2..8, safety enable at bit 11
// - output word: transistor outputs one..four at bits 0..3
// - output word: relay output a at bit 4 while closed
// - output word: alarm relay at bit 8; all other output bits zero
// - comm control: inputs from command word, adds commands at bits 13..15
// - comm control: command bits shown in true polarity, never inverted
// - option view: option inputs 1..16 at bits 0..15, digits one and two
// - option view: option outputs 1..8 at bits 0..7, digit three; four unused
// - three monitor selections: local, communications, option card terminals
package tsd_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // register map, byte addresses on the low eight address bits
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_IN_WORD = 8'h04;
  localparam logic [7:0] OFF_OUT_WORD = 8'h08;
  localparam logic [7:0] OFF_DIGITS = 8'h0C;

  // control register fields
  localparam int CTRL_FMT_BIT = 0;
  localparam int CTRL_SEL_LSB = 1;
  localparam int CTRL_VIEW_BIT = 3;
  localparam int CTRL_W = 4;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////////
  // packed word bit positions
  localparam int IN_FWD = 0;
  localparam int IN_REV = 1;
  localparam int IN_GEN_LSB = 2;
  localparam int IN_GEN7 = 8;
  localparam int IN_EN = 11;
  localparam int IN_XF = 13;
  localparam int IN_XR = 14;
  localparam int IN_RST = 15;
  localparam int OUT_TR_LSB = 0;
  localparam int OUT_RELAY = 4;
  localparam int OUT_ALARM = 8;
  localparam logic [15:0] IN_MASK_COMM = 16'hE9FF;
  localparam logic [15:0] OUT_MASK = 16'h011F;

  // segment patterns, bit 0 is segment a, bit 7 is dp, one means lit
  localparam logic [7:0] SEG_OFF = 8'h00;
  localparam logic [7:0] SEG_DASH = 8'h40;

  // monitor selection, gray along local -> comm -> option
  typedef enum logic [1:0] {
    SEL_LOCAL = 2'h0,
    SEL_COMM = 2'h1,
    SEL_OPTION = 2'h3
  } tsd_sel_t;

  ////////////////////////////////////////////////////////////////////////////////
  // hex digit glyph, shared by the digit encoder and its checks
  function automatic logic [7:0] hex_glyph(input logic [3:0] n);
    case (n)
      4'h0: hex_glyph = 8'h3F;
      4'h1: hex_glyph = 8'h06;
      4'h2: hex_glyph = 8'h5B;
      4'h3: hex_glyph = 8'h4F;
      4'h4: hex_glyph = 8'h66;
      4'h5: hex_glyph = 8'h6D;
      4'h6: hex_glyph = 8'h7D;
      4'h7: hex_glyph = 8'h07;
      4'h8: hex_glyph = 8'h7F;
      4'h9: hex_glyph = 8'h6F;
      4'hA: hex_glyph = 8'h77;
      4'hB: hex_glyph = 8'h7C;
      4'hC: hex_glyph = 8'h39;
      4'hD: hex_glyph = 8'h5E;
      4'hE: hex_glyph = 8'h79;
      default: hex_glyph = 8'h71;
    endcase
  endfunction : hex_glyph

endpackage : tsd_pkg

// *** rtl/tsd_hex_digits.sv ***
// module: splits a 16-bit word into four hex digit segment patterns
module tsd_hex_digits (
  // packed word
  input wire logic [15:0] word,
  // patterns, digit one in the low byte
  output logic [31:0] glyphs
);
  import tsd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // one glyph per nibble; purely combinational, the caller registers it
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      glyphs[i*8 +: 8] = hex_glyph(word[i*4 +: 4]);
    end
  end

endmodule : tsd_hex_digits

// *** rtl/tsd_encoder.sv ***
// module: terminal status display encoder with an AXI4-Lite register slave
//
// The AXI4-Lite slave port and the placing of the registers were chosen for this implementation.
module tsd_encoder #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // local input terminals
  input wire logic forward_run_input,
  input wire logic reverse_run_input,
  input wire logic [6:0] general_inputs,
  input wire logic safety_enable_input,
  // local output terminals
  input wire logic [3:0] transistor_outputs,
  input wire logic relay_output_a,
  input wire logic alarm_relay_output,
  // communications command word, laid out as the input word
  input wire logic [15:0] comm_command_word,
  // option card terminals
  input wire logic [15:0] option_inputs,
  input wire logic [7:0] option_outputs,
  // display digits, bit 0 segment a, bit 7 dp
  output logic [7:0] digit_one,
  output logic [7:0] digit_two,
  output logic [7:0] digit_three,
  output logic [7:0] digit_four,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  // axi4-lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);
  import tsd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [CTRL_W-1:0] ctrl;
  logic hex_format;
  logic view_outputs;
  tsd_sel_t sel;
  logic [15:0] in_word;
  logic [15:0] out_word;
  logic [15:0] next_in_word;
  logic [15:0] next_out_word;
  logic [15:0] hex_word;
  logic [31:0] hex_glyphs;
  logic [7:0] next_digit_one;
  logic [7:0] next_digit_two;
  logic [7:0] next_digit_three;
  logic [7:0] next_digit_four;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic next_aw_held;
  logic next_w_held;
  logic next_rvalid;
  logic [31:0] rd_word;
  logic rd_ok;

  // control fields; the unused gray code 2'h2 falls back to local terminals
  assign hex_format = ctrl[CTRL_FMT_BIT];
  assign view_outputs = ctrl[CTRL_VIEW_BIT];
  assign sel = (ctrl[CTRL_SEL_LSB +: 2] == 2'h2) ? SEL_LOCAL
             : tsd_sel_t'(ctrl[CTRL_SEL_LSB +: 2]);

  ////////////////////////////////////////////////////////////////////////////////
  // pack the selected source into input and output words
  always_comb begin
    next_in_word = 16'h0000;
    next_out_word = 16'h0000;
    case (sel)
      SEL_OPTION: begin
        next_in_word = option_inputs;
        next_out_word[7:0] = option_outputs;
      end
      SEL_COMM: begin
        // true polarity: only masking, no inversion of any command bit
        next_in_word = comm_command_word & IN_MASK_COMM;
        next_out_word[OUT_TR_LSB +: 4] = transistor_outputs;
        next_out_word[OUT_RELAY] = relay_output_a;
        next_out_word[OUT_ALARM] = alarm_relay_output;
      end
      default: begin
        next_in_word[IN_FWD] = forward_run_input;
        next_in_word[IN_REV] = reverse_run_input;
        next_in_word[IN_GEN_LSB +: 7] = general_inputs;
        next_in_word[IN_EN] = safety_enable_input;
        next_out_word[OUT_TR_LSB +: 4] = transistor_outputs;
        next_out_word[OUT_RELAY] = relay_output_a;
        next_out_word[OUT_ALARM] = alarm_relay_output;
      end
    endcase
  end

  // snapshot: the digits never see a terminal change mid-update
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      in_word <= 16'h0000;
      out_word <= 16'h0000;
    end else begin
      in_word <= next_in_word;
      out_word <= next_out_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // hex presentation of whichever word software picked
  assign hex_word = view_outputs ? out_word : in_word;

  tsd_hex_digits u_hex (
    .word(hex_word),
    .glyphs(hex_glyphs)
  );

  // digit patterns for the current format and selection
  always_comb begin
    next_digit_one = SEG_OFF;
    next_digit_two = SEG_OFF;
    next_digit_three = SEG_OFF;
    next_digit_four = SEG_OFF;
    if (hex_format) begin
      next_digit_one = hex_glyphs[7:0];
      next_digit_two = hex_glyphs[15:8];
      next_digit_three = hex_glyphs[23:16];
      next_digit_four = hex_glyphs[31:24];
    end else if (sel == SEL_OPTION) begin
      next_digit_one = in_word[7:0];
      next_digit_two = in_word[15:8];
      next_digit_three = out_word[7:0];
    end else if (in_word == 16'h0000 && out_word == 16'h0000) begin
      next_digit_one = SEG_DASH;
      next_digit_two = SEG_DASH;
      next_digit_three = SEG_DASH;
      next_digit_four = SEG_DASH;
    end else begin
      next_digit_one = in_word[7:0];
      next_digit_two = {in_word[IN_RST], in_word[IN_XR], in_word[IN_XF], 1'b0,
                        in_word[IN_EN], 2'b00, in_word[IN_GEN7]};
      next_digit_three = {3'b000, out_word[OUT_RELAY], out_word[OUT_TR_LSB +: 4]};
      next_digit_four = {7'b0000000, out_word[OUT_ALARM]};
    end
  end

  // digit registers feed the display pins directly
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      digit_one <= SEG_OFF;
      digit_two <= SEG_OFF;
      digit_three <= SEG_OFF;
      digit_four <= SEG_OFF;
    end else begin
      digit_one <= next_digit_one;
      digit_two <= next_digit_two;
      digit_three <= next_digit_three;
      digit_four <= next_digit_four;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // write channels: address and data captured independently, one of each held
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign next_aw_held = (aw_held && !do_write) || (s_axi_awvalid && s_axi_awready);
  assign next_w_held = (w_held && !do_write) || (s_axi_wvalid && s_axi_wready);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      aw_held <= 1'b0;
      s_axi_awready <= 1'b0;
      aw_addr <= 8'h00;
    end else begin
      aw_held <= next_aw_held;
      s_axi_awready <= !next_aw_held;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr[7:0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      w_held <= 1'b0;
      s_axi_wready <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else begin
      w_held <= next_w_held;
      s_axi_wready <= !next_w_held;
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  // response; status registers accept and ignore writes, holes answer slverr
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      if (aw_addr == OFF_CTRL || aw_addr == OFF_IN_WORD || aw_addr == OFF_OUT_WORD
          || aw_addr == OFF_DIGITS) begin
        s_axi_bresp <= RESP_OKAY;
      end else begin
        s_axi_bresp <= RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // control register, low byte lane only
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl <= CTRL_RESET;
    end else if (do_write && aw_addr == OFF_CTRL && w_strb[0]) begin
      ctrl <= w_data[CTRL_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read decode
  always_comb begin
    rd_word = 32'h00000000;
    rd_ok = 1'b1;
    if (s_axi_araddr[7:0] == OFF_CTRL) begin
      rd_word[CTRL_W-1:0] = ctrl;
    end else if (s_axi_araddr[7:0] == OFF_IN_WORD) begin
      rd_word[15:0] = in_word;
    end else if (s_axi_araddr[7:0] == OFF_OUT_WORD) begin
      rd_word[15:0] = out_word;
    end else if (s_axi_araddr[7:0] == OFF_DIGITS) begin
      rd_word = {digit_four, digit_three, digit_two, digit_one};
    end else begin
      rd_ok = 1'b0;
    end
  end

  // read channel: data one cycle after the address is taken
  assign next_rvalid = (s_axi_rvalid && !s_axi_rready) || (s_axi_arvalid && s_axi_arready);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !next_rvalid;
      s_axi_rvalid <= next_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  sequence s_seg_local;
    !hex_format && sel != SEL_OPTION;
  endsequence

  sequence s_aw_and_w_taken;
    (s_axi_awvalid && s_axi_awready) && (s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
  endsequence

  property p_dash_row;
    s_seg_local and (in_word == 16'h0000 && out_word == 16'h0000) |=>
      {digit_four, digit_three, digit_two, digit_one} == 32'h40404040;
  endproperty
  a_dash_row: assert property (p_dash_row)
    else $error("dash row missing with all terminals off");

  property p_seg_inputs;
    s_seg_local and (in_word != 16'h0000) |=>
      digit_one == $past(in_word[7:0]) && digit_two[0] == $past(in_word[8])
      && digit_two[3] == $past(in_word[11]) && digit_two[7:5] == $past(in_word[15:13]);
  endproperty
  a_seg_inputs: assert property (p_seg_inputs)
    else $error("segment digits one and two do not follow the input word");

  property p_seg_outputs;
    s_seg_local and (out_word != 16'h0000) |=>
      digit_three == {3'b000, $past(out_word[4:0])} && digit_four == {7'b0, $past(out_word[8])};
  endproperty
  a_seg_outputs: assert property (p_seg_outputs)
    else $error("segment digits three and four do not follow the output word");

  property p_hex_order;
    hex_format && !view_outputs |=>
      digit_four == hex_glyph($past(in_word[15:12])) && digit_one == hex_glyph($past(in_word[3:0]));
  endproperty
  a_hex_order: assert property (p_hex_order)
    else $error("hex digit order wrong");

  property p_local_pack;
    sel == SEL_LOCAL |=> in_word == {4'h0, $past(safety_enable_input), 2'b00,
      $past(general_inputs), $past(reverse_run_input), $past(forward_run_input)};
  endproperty
  a_local_pack: assert property (p_local_pack)
    else $error("local input word packing wrong");

  // the snapshot lags the selection by one edge, so judge the word that this selection made
  property p_unassigned_zero;
    sel != SEL_OPTION |=> (in_word & ~IN_MASK_COMM) == 16'h0000 && (out_word & ~OUT_MASK) == 16'h0000;
  endproperty
  a_unassigned_zero: assert property (p_unassigned_zero)
    else $error("unassigned bit set");

  property p_comm_true;
    sel == SEL_COMM |=> in_word == ($past(comm_command_word) & IN_MASK_COMM);
  endproperty
  a_comm_true: assert property (p_comm_true)
    else $error("comm word not shown in true polarity");

  // two edges of option segment view: one to snapshot the card, one to form the digits
  sequence s_seg_option;
    !hex_format && sel == SEL_OPTION;
  endsequence

  property p_option_seg;
    s_seg_option ##1 s_seg_option |=>
      digit_two == $past(option_inputs[15:8], 2) && digit_three == $past(option_outputs, 2)
      && digit_four == SEG_OFF;
  endproperty
  a_option_seg: assert property (p_option_seg)
    else $error("option card segment view wrong");

  property p_reset_clear;
    disable iff (1'b0) sys_rst |=> digit_one == SEG_OFF && digit_four == SEG_OFF;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("digits not cleared by reset");

  property p_write_resp;
    s_aw_and_w_taken |-> ##[2:2] s_axi_bvalid;
  endproperty
  a_write_resp: assert property (p_write_resp)
    else $error("write response not two cycles after both channels taken");

endmodule : tsd_encoder

// *** rtl/tsd_unused_placeholder_removed.sv ***
// file: intentionally empty; no module

// *** testbench/tsd_term_model.sv ***
// partner model: drive control terminal logic feeding the encoder's terminal inputs
module tsd_term_model (
  // clock and requested terminal pattern
  input wire logic clock,
  input wire logic [55:0] pattern,
  // local input terminals: fwd, rev, general one..seven, enable
  output logic [9:0] in_lvl,
  // local outputs: transistor one..four, relay a, alarm relay
  output logic [5:0] out_lvl,
  // communications command word
  output logic [15:0] comm_lvl,
  // option card inputs and outputs
  output logic [15:0] opt_in_lvl,
  output logic [7:0] opt_out_lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////////////////////
  // contacts settle on a clock edge, so the encoder never sees a change mid-cycle
  always @(posedge clock) begin
    in_lvl <= pattern[9:0];
    out_lvl <= pattern[15:10];
    comm_lvl <= pattern[31:16];
    opt_in_lvl <= pattern[47:32];
    opt_out_lvl <= pattern[55:48];
  end
endmodule : tsd_term_model

// *** testbench/tb_tsd_encoder.sv ***
// testbench: self-checking bench for the terminal status display encoder
module tb_tsd_encoder;
  timeunit 1ns;
  timeprecision 1ps;
  import tsd_pkg::*;
  ////////////////////////////////////////////////////////////////////////////////
  // glyphs written out here so expectations never share the design's function
  localparam logic [7:0] glyph [16] = '{8'h3F, 8'h06, 8'h5B, 8'h4F, 8'h66, 8'h6D,
    8'h7D, 8'h07, 8'h7F, 8'h6F, 8'h77, 8'h7C, 8'h39, 8'h5E, 8'h79, 8'h71};
  localparam logic [3:0] ctab [10] = '{4'h0, 4'h1, 4'h9, 4'h2, 4'h3, 4'hB, 4'h6,
    4'h7, 4'hF, 4'h4};
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic dig_go = 1'b0;
  logic [55:0] pattern;
  logic [9:0] in_lvl;
  logic [5:0] out_lvl;
  logic [15:0] comm_lvl;
  logic [15:0] opt_in_lvl;
  logic [7:0] opt_out_lvl;
  logic [7:0] digit_one;
  logic [7:0] digit_two;
  logic [7:0] digit_three;
  logic [7:0] digit_four;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awready;
  logic s_axi_wready;
  logic s_axi_bvalid;
  logic s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp;
  logic [1:0] s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [1:0] exp_wr [$];
  logic [33:0] exp_rd [$];
  logic [31:0] exp_dg [$];
  int err_total = 0;
  int total_checks = 0;
  int seed = 28;

  ////////////////////////////////////////////////////////////////////////////////
  // far side and block under test; prot inputs tied, they are ignored
  tsd_term_model term_u (.clock(clock), .pattern(pattern), .in_lvl(in_lvl),
    .out_lvl(out_lvl), .comm_lvl(comm_lvl), .opt_in_lvl(opt_in_lvl),
    .opt_out_lvl(opt_out_lvl));
  tsd_encoder dut_u (.clock(clock), .sys_rst(sys_rst),
    .forward_run_input(in_lvl[0]), .reverse_run_input(in_lvl[1]),
    .general_inputs(in_lvl[8:2]), .safety_enable_input(in_lvl[9]),
    .transistor_outputs(out_lvl[3:0]), .relay_output_a(out_lvl[4]),
    .alarm_relay_output(out_lvl[5]), .comm_command_word(comm_lvl),
    .option_inputs(opt_in_lvl), .option_outputs(opt_out_lvl),
    .digit_one(digit_one), .digit_two(digit_two), .digit_three(digit_three),
    .digit_four(digit_four), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp));

  initial begin
    forever #2.5 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // expected digits and words for a control value and a terminal pattern
  function automatic logic [31:0] calc(input logic [3:0] c, input logic [55:0] t,
                                       output logic [15:0] iw, output logic [15:0] ow);
    logic [15:0] w;
    iw = {4'h0, t[9], 2'h0, t[8:0]};
    ow = {7'h00, t[15], 3'h0, t[14:10]};
    if (c[2:1] == 2'h1) iw = t[31:16] & 16'hE9FF;
    if (c[2:1] == 2'h3) begin
      iw = t[47:32];
      ow = {8'h00, t[55:48]};
    end
    w = c[3] ? ow : iw;
    if (c[0]) return {glyph[w[15:12]], glyph[w[11:8]], glyph[w[7:4]], glyph[w[3:0]]};
    if (c[2:1] == 2'h3) return {8'h00, t[55:48], t[47:32]};
    if (iw == 16'h0 && ow == 16'h0) return 32'h40404040;
    return {7'h00, ow[8], 3'h0, ow[4:0], iw[15:13], 1'b0, iw[11], 2'h0, iw[8], iw[7:0]};
  endfunction : calc

  task automatic check(input logic [33:0] got, input logic [33:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  // master holds each channel until its own ready edge, answers until valid seen
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] r);
    exp_wr.push_back(r);
    @(posedge clock);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_bready <= 1'b1;
    // no cycle budget here: only the watchdog ends a wait for the answer
    forever begin
      @(posedge clock);
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    exp_rd.push_back(e);
    @(posedge clock);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge clock);
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
  endtask : rd

  // one pulse per call; callers always let an edge pass between calls
  task automatic note_dig(input logic [31:0] e);
    exp_dg.push_back(e);
    dig_go <= 1'b1;
    @(posedge clock);
    dig_go <= 1'b0;
  endtask : note_dig

  task automatic test_done();
    $display("checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////////////////////
  // monitor: oldest note against each result as it appears
  always @(posedge clock) begin
    if (s_axi_bvalid && s_axi_bready) check({32'h0, s_axi_bresp}, {32'h0, exp_wr.pop_front()}, "bresp");
    if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, exp_rd.pop_front(), "read");
    if (dig_go) check({2'h0, digit_four, digit_three, digit_two, digit_one}, {2'h0, exp_dg.pop_front()}, "digits");
  end

  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    test_done();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [3:0] c;
    logic [15:0] iw;
    logic [15:0] ow;
    logic [31:0] e;
    pattern = {$random(seed), 24'hA5C3F1};
    repeat (2) @(posedge clock);
    note_dig(32'h0);
    sys_rst <= 1'b0;
    foreach (ctab[i]) begin
      c = ctab[i];
      wr(OFF_CTRL, ($random(seed) & 32'hFFFFFFF0) | {28'h0, c}, 4'hF, RESP_OKAY);
      rd(OFF_CTRL, {RESP_OKAY, 28'h0, c});
      for (int k = 0; k < 4; k++) begin
        @(posedge clock);
        if (k == 0) pattern <= 56'h0;
        else if (k == 3) pattern <= 56'h1 << ($unsigned($random(seed)) % 56);
        else pattern <= {$random(seed), 24'h0} ^ 56'($unsigned($random(seed)));
        repeat (4) @(posedge clock);
        e = calc(c, pattern, iw, ow);
        note_dig(e);
        rd(OFF_IN_WORD, {RESP_OKAY, 16'h0, iw});
        rd(OFF_OUT_WORD, {RESP_OKAY, 16'h0, ow});
        rd(OFF_DIGITS, {RESP_OKAY, e});
      end
      $display("test ctrl %h done", c);
    end
    // refused and masked accesses leave the control value alone
    wr(OFF_CTRL, 32'h1, 4'h0, RESP_OKAY);
    wr(OFF_IN_WORD, 32'hF, 4'hF, RESP_OKAY);
    wr(8'h20, 32'hF, 4'hF, RESP_SLVERR);
    rd(8'h20, {RESP_SLVERR, 32'h0});
    rd(OFF_CTRL, {RESP_OKAY, 28'h0, c});
    $display("test refusals done");
    repeat (4) @(posedge clock);
    test_done();
  end
endmodule : tb_tsd_encoder
